//--- hdl/itcf_map.svh
/*
 * Register offsets, field positions and reset values of the trap and
 * interrupt control flags block.
 * Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
 */
`ifndef ITCF_MAP_SVH
`define ITCF_MAP_SVH

`define ITCF_OFF_TRAP_CTL 12'h000
`define ITCF_OFF_VEC_CTL 12'h004
`define ITCF_OFF_REQ_FLAGS 12'h008
`define ITCF_OFF_CPU_PRIO 12'h00C
`define ITCF_OFF_EXT_IN 12'h010

`define ITCF_RESET_16 16'h0000
// writable masks of the three documented registers
`define ITCF_TRAP_CTL_MASK 16'hFFDE
`define ITCF_VEC_CTL_MASK 16'h8007
`define ITCF_REQ_FLAGS_MASK 16'h3FEF

`define ITCF_B_NEST_DIS 15
`define ITCF_B_OVA_FLAG 14
`define ITCF_B_OVB_FLAG 13
`define ITCF_B_COVA_FLAG 12
`define ITCF_B_COVB_FLAG 11
`define ITCF_B_OVA_EN 10
`define ITCF_B_OVB_EN 9
`define ITCF_B_COV_EN 8
`define ITCF_B_SHIFT_ERR 7
`define ITCF_B_DIV0_ERR 6
`define ITCF_B_MATH_ERR 4
`define ITCF_B_ADDR_ERR 3
`define ITCF_B_STACK_ERR 2
`define ITCF_B_OSC_FAIL 1
`define ITCF_B_ALT_TABLE 15
`define ITCF_B_HOLD_OFF 14
`define ITCF_B_EXT0_FLAG 0

`endif

//--- hdl/itcf_pkg.sv
/*
 * Types of the trap and interrupt control flags block.
 * Assumes itcf_map.svh supplies the numeric constants.
 */
package itcf_pkg;
    // accumulator events from the core, one-cycle pulses
    typedef struct packed {
        logic ova;
        logic ovb;
        logic cova;
        logic covb;
    } itcf_acc_evt_t;

    // trap causes from the core, one-cycle pulses
    typedef struct packed {
        logic shift_err;
        logic div0_err;
        logic math_other;
        logic addr_err;
        logic stack_err;
        logic osc_fail;
    } itcf_trap_evt_t;

    typedef enum logic [1:0] {
        ITCF_RD_IDLE = 2'b00,
        ITCF_RD_RESP = 2'b01
    } itcf_rd_state_t;

    typedef enum logic [1:0] {
        ITCF_WR_IDLE = 2'b00,
        ITCF_WR_RESP = 2'b01
    } itcf_wr_state_t;
endpackage

//--- hdl/itcf_top.sv
/*
 * Trap and nesting control, vector and edge control, first request flags,
 * behind an AXI4-Lite slave.
 * Assumes event inputs are one-cycle pulses synchronous to clk_i and
 * external interrupt lines are already synchronous.
 */
`timescale 1ns/1ps
`include "itcf_map.svh"

module itcf_top
    import itcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire itcf_acc_evt_t acc_evt_i,
    input wire itcf_trap_evt_t trap_evt_i,
    input wire logic hold_off_active_i,
    input wire logic [2:0] ext_irq_i,
    input wire logic [12:0] periph_req_i,
    output logic nesting_disable_o,
    output logic alternate_table_select_o,
    output logic [2:0] cpu_priority_level_o,
    output logic [15:0] request_flags_o,
    output logic ova_trap_o,
    output logic ovb_trap_o,
    output logic cov_trap_o
);

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    itcf_wr_state_t wr_state_q, wr_state_d;
    itcf_rd_state_t rd_state_q, rd_state_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic [1:0] bresp_q, bresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic wr_fire;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] wr_bytes;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [11:0] rd_addr;
    logic hit_trap;
    logic hit_vec;
    logic hit_req;
    logic hit_prio;
    logic hit_ext;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] trap_ctl_q, trap_ctl_d;
    logic [15:0] vec_ctl_q, vec_ctl_d;
    logic [15:0] req_q, req_d;
    logic [2:0] prio_q, prio_d;
    logic [2:0] ext_prev_q, ext_prev_d;
    logic [15:0] req_set;
    wire [2:0] ext_hit;
    logic [15:0] trap_wr_val;
    logic [15:0] vec_wr_val;
    logic [15:0] req_wr_val;
    logic ova_trap_q, ova_trap_d;
    logic ovb_trap_q, ovb_trap_d;
    logic cov_trap_q, cov_trap_d;

    assign wr_fire = aw_have_q && w_have_q && (wr_state_q == ITCF_WR_IDLE);
    assign wr_lo = wr_fire && w_strb_q[0];
    assign wr_hi = wr_fire && w_strb_q[1];
    assign wr_bytes = w_data_q[15:0];
    assign rd_addr = {s_axi_araddr_i[11:2], 2'b00};
    // one decode of the held address serves the response and every register
    assign hit_trap = (aw_addr_q == `ITCF_OFF_TRAP_CTL);
    assign hit_vec = (aw_addr_q == `ITCF_OFF_VEC_CTL);
    assign hit_req = (aw_addr_q == `ITCF_OFF_REQ_FLAGS);
    assign hit_prio = (aw_addr_q == `ITCF_OFF_CPU_PRIO);
    assign hit_ext = (aw_addr_q == `ITCF_OFF_EXT_IN);
    // reserved positions are dropped before they reach the flops
    assign trap_wr_val = wr_bytes & `ITCF_TRAP_CTL_MASK;
    assign vec_wr_val = wr_bytes & `ITCF_VEC_CTL_MASK;
    assign req_wr_val = wr_bytes & `ITCF_REQ_FLAGS_MASK;

    always_comb begin
        wr_state_d = wr_state_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bresp_d = bresp_q;
        wr_ok = hit_trap || hit_vec || hit_req || hit_prio || hit_ext;
        if (s_axi_awvalid_i && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = {s_axi_awaddr_i[11:2], 2'b00};
        end
        if (s_axi_wvalid_i && !w_have_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata_i;
            w_strb_d = s_axi_wstrb_i;
        end
        case (wr_state_q)
            ITCF_WR_IDLE: begin
                if (aw_have_q && w_have_q) begin
                    wr_state_d = ITCF_WR_RESP;
                    bresp_d = wr_ok ? 2'b00 : 2'b10;
                end
            end
            ITCF_WR_RESP: begin
                if (s_axi_bready_i) begin
                    wr_state_d = ITCF_WR_IDLE;
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                end
            end
            default: wr_state_d = ITCF_WR_IDLE;
        endcase
        // handshake outputs follow the next state so they leave flops
        awready_d = !aw_have_d;
        wready_d = !w_have_d;
        bvalid_d = (wr_state_d == ITCF_WR_RESP);
    end

    // write channel registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_state_q <= ITCF_WR_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bresp_q <= 2'b00;
            // both slots are empty out of reset, so both readies start high
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (rd_addr)
            `ITCF_OFF_TRAP_CTL: rd_word = {16'h0000, trap_ctl_q & `ITCF_TRAP_CTL_MASK};
            `ITCF_OFF_VEC_CTL: rd_word = {16'h0000, vec_ctl_q[15], hold_off_active_i,
                                          11'h000, vec_ctl_q[2:0]};
            `ITCF_OFF_REQ_FLAGS: rd_word = {16'h0000, req_q & `ITCF_REQ_FLAGS_MASK};
            `ITCF_OFF_CPU_PRIO: rd_word = {29'h0000_0000, prio_q};
            `ITCF_OFF_EXT_IN: rd_word = {29'h0000_0000, ext_prev_q};
            default: rd_ok = 1'b0;
        endcase
        rd_state_d = rd_state_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rd_state_q)
            ITCF_RD_IDLE: begin
                if (s_axi_arvalid_i) begin
                    rd_state_d = ITCF_RD_RESP;
                    rdata_d = rd_ok ? rd_word : 32'h0000_0000;
                    rresp_d = rd_ok ? 2'b00 : 2'b10;
                end
            end
            ITCF_RD_RESP: begin
                if (s_axi_rready_i) begin
                    rd_state_d = ITCF_RD_IDLE;
                end
            end
            default: rd_state_d = ITCF_RD_IDLE;
        endcase
        arready_d = (rd_state_d == ITCF_RD_IDLE);
        rvalid_d = (rd_state_d == ITCF_RD_RESP);
    end

    // read channel registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_state_q <= ITCF_RD_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end else begin
            rd_state_q <= rd_state_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge detect, one slice per external line
    for (genvar g = 0; g < 3; g++) begin : g_edge
        // polarity one catches a falling edge
        assign ext_hit[g] = vec_ctl_q[g] ? (ext_prev_q[g] && !ext_irq_i[g])
                                         : (!ext_prev_q[g] && ext_irq_i[g]);
    end

    ////////////////////////////////////////////////////////////////////////
    // flag and control next state
    always_comb begin
        ext_prev_d = ext_irq_i;
        // peripheral order matches bits 13..5 and 3..1
        req_set = {2'b00, periph_req_i[12:4], 1'b0, periph_req_i[3:1], 1'b0};
        req_set[`ITCF_B_EXT0_FLAG] = ext_hit[0] | periph_req_i[0];

        trap_ctl_d = trap_ctl_q;
        vec_ctl_d = vec_ctl_q;
        req_d = req_q;
        prio_d = prio_q;
        if (wr_lo && hit_trap) begin
            trap_ctl_d[7:0] = trap_wr_val[7:0];
        end
        if (wr_hi && hit_trap) begin
            trap_ctl_d[15:8] = trap_wr_val[15:8];
        end
        if (wr_lo && hit_vec) begin
            vec_ctl_d[2:0] = vec_wr_val[2:0];
        end
        if (wr_hi && hit_vec) begin
            vec_ctl_d[15] = vec_wr_val[15];
        end
        if (wr_lo && hit_req) begin
            req_d[7:0] = req_wr_val[7:0];
        end
        if (wr_hi && hit_req) begin
            req_d[15:8] = req_wr_val[15:8];
        end
        // a frozen level ignores the write but the bus still answers it
        if (wr_lo && hit_prio && !trap_ctl_q[`ITCF_B_NEST_DIS]) begin
            prio_d = wr_bytes[2:0];
        end
        // sources set after the software write so a set wins
        req_d = req_d | req_set;
        ova_trap_d = acc_evt_i.ova && trap_ctl_q[`ITCF_B_OVA_EN];
        ovb_trap_d = acc_evt_i.ovb && trap_ctl_q[`ITCF_B_OVB_EN];
        cov_trap_d = (acc_evt_i.cova || acc_evt_i.covb) && trap_ctl_q[`ITCF_B_COV_EN];
        // trap sets follow the writes above, so a trap beats a clear
        if (ova_trap_d) begin
            trap_ctl_d[`ITCF_B_OVA_FLAG] = 1'b1;
        end
        if (ovb_trap_d) begin
            trap_ctl_d[`ITCF_B_OVB_FLAG] = 1'b1;
        end
        if (cov_trap_d && acc_evt_i.cova) begin
            trap_ctl_d[`ITCF_B_COVA_FLAG] = 1'b1;
        end
        if (cov_trap_d && acc_evt_i.covb) begin
            trap_ctl_d[`ITCF_B_COVB_FLAG] = 1'b1;
        end
        if (trap_evt_i.shift_err) begin
            trap_ctl_d[`ITCF_B_SHIFT_ERR] = 1'b1;
        end
        if (trap_evt_i.div0_err) begin
            trap_ctl_d[`ITCF_B_DIV0_ERR] = 1'b1;
        end
        if (trap_evt_i.shift_err || trap_evt_i.div0_err || trap_evt_i.math_other
            || ova_trap_d || ovb_trap_d || cov_trap_d) begin
            trap_ctl_d[`ITCF_B_MATH_ERR] = 1'b1;
        end
        if (trap_evt_i.addr_err) begin
            trap_ctl_d[`ITCF_B_ADDR_ERR] = 1'b1;
        end
        if (trap_evt_i.stack_err) begin
            trap_ctl_d[`ITCF_B_STACK_ERR] = 1'b1;
        end
        if (trap_evt_i.osc_fail) begin
            trap_ctl_d[`ITCF_B_OSC_FAIL] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_ctl_q <= `ITCF_RESET_16;
            vec_ctl_q <= `ITCF_RESET_16;
            req_q <= `ITCF_RESET_16;
            prio_q <= 3'h0;
            ext_prev_q <= 3'h0;
            ova_trap_q <= 1'b0;
            ovb_trap_q <= 1'b0;
            cov_trap_q <= 1'b0;
        end else begin
            trap_ctl_q <= trap_ctl_d;
            vec_ctl_q <= vec_ctl_d;
            req_q <= req_d;
            prio_q <= prio_d;
            ext_prev_q <= ext_prev_d;
            ova_trap_q <= ova_trap_d;
            ovb_trap_q <= ovb_trap_d;
            cov_trap_q <= cov_trap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // ready is high while the holding slot is empty
    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign nesting_disable_o = trap_ctl_q[`ITCF_B_NEST_DIS];
    assign alternate_table_select_o = vec_ctl_q[`ITCF_B_ALT_TABLE];
    assign cpu_priority_level_o = prio_q;
    assign request_flags_o = req_q;
    assign ova_trap_o = ova_trap_q;
    assign ovb_trap_o = ovb_trap_q;
    assign cov_trap_o = cov_trap_q;

endmodule

//--- testbench/itcf_core_model.sv
/* Core and peripheral event source model.
   Turns one-cycle bench commands into registered event pulses. */
`timescale 1ns/1ps
module itcf_core_model
    import itcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic [9:0] trap_cmd_i,
    input wire logic [12:0] req_cmd_i,
    output itcf_acc_evt_t acc_evt_o,
    output itcf_trap_evt_t trap_evt_o,
    output logic [12:0] periph_req_o
);
    // registered so every source gives a clean one-cycle pulse
    always_ff @(posedge clk_i) begin
        {acc_evt_o, trap_evt_o} <= trap_cmd_i;
        periph_req_o <= req_cmd_i;
    end
endmodule

//--- testbench/itcf_properties.sv
/* Port checker of itcf_top.
   Bound to every itcf_top; sees its ports only. */
`timescale 1ns/1ps
module itcf_properties
    import itcf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_bvalid_o,
    input wire itcf_acc_evt_t acc_evt_i,
    input wire logic [12:0] periph_req_i,
    input wire logic nesting_disable_o,
    input wire logic [2:0] cpu_priority_level_o,
    input wire logic [15:0] request_flags_o,
    input wire logic ova_trap_o,
    input wire logic cov_trap_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reset_all_zero_a: assert property ($fell(rst_i) |->
        request_flags_o == 16'h0000 && !nesting_disable_o) else $error("not zero after reset");
    ova_trap_cause_a: assert property (ova_trap_o |-> $past(acc_evt_i.ova))
        else $error("overflow trap without event");
    cov_trap_cause_a: assert property (cov_trap_o |->
        $past(acc_evt_i.cova || acc_evt_i.covb)) else $error("catastrophic trap without event");
    converter_flag_set_a: assert property (periph_req_i[12] |=> request_flags_o[13])
        else $error("converter flag not set");
    ext0_flag_set_a: assert property (periph_req_i[0] |=> request_flags_o[0])
        else $error("ext0 flag not set");
    reserved_flags_zero_a: assert property (request_flags_o[15:14] == 2'b00 &&
        !request_flags_o[4]) else $error("reserved flag bit set");
    flag_sticky_a: assert property ($fell(request_flags_o[13]) |->
        $rose(s_axi_bvalid_o)) else $error("flag cleared without write");
    priority_frozen_a: assert property ($changed(cpu_priority_level_o) |->
        !$past(nesting_disable_o)) else $error("priority changed while frozen");
    read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
endmodule

bind itcf_top itcf_properties i_props (.*);

//--- testbench/tb.sv
/* Self-checking bench of itcf_top.
   Drives AXI4-Lite and events; read results checked from a queue. */
`timescale 1ns/1ps
`include "itcf_map.svh"
module tb
    import itcf_pkg::*;
;
    localparam logic [11:0] TC = `ITCF_OFF_TRAP_CTL, VC = `ITCF_OFF_VEC_CTL;
    localparam logic [11:0] RF = `ITCF_OFF_REQ_FLAGS, PL = `ITCF_OFF_CPU_PRIO;
    localparam logic [15:0] CTL [12] = '{16'h0700, 16'h0700, 16'h0700, 16'h0700, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0600};
    localparam logic [9:0] CMD [12] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h3c0, 10'h020,
        10'h010, 10'h008, 10'h004, 10'h002, 10'h001, 10'h0c0};
    localparam logic [15:0] EXP [12] = '{16'h4710, 16'h2710, 16'h1710, 16'h0f10, 16'h0000,
        16'h0090, 16'h0050, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0600};
    logic clk_i;
    logic rst_i = 1'b1;
    logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1, hold_off_active_i = 1'b0;
    logic [2:0] ext_irq_i = 3'h0;
    logic [9:0] trap_cmd = 10'h000;
    logic [12:0] req_cmd = 13'h0000, m;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic nesting_disable_o, alternate_table_select_o, ova_trap_o, ovb_trap_o, cov_trap_o;
    logic [2:0] cpu_priority_level_o;
    logic [15:0] request_flags_o;
    logic [12:0] periph_req_i;
    itcf_acc_evt_t acc_evt_i;
    itcf_trap_evt_t trap_evt_i;
    logic [33:0] exp_q [$];
    logic [1:0] bexp_q [$];
    int failures = 0, compares = 0, cycles = 0;

    itcf_top i_dut (.*);
    itcf_core_model i_core (.clk_i(clk_i), .trap_cmd_i(trap_cmd), .req_cmd_i(req_cmd),
        .acc_evt_o(acc_evt_i), .trap_evt_o(trap_evt_i), .periph_req_o(periph_req_i));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // bready stays high, so the answer is taken at the edge it is seen
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        bexp_q.push_back((a inside {TC, VC, RF, PL, `ITCF_OFF_EXT_IN}) ? 2'b00 : 2'b10);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {16'h0000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] r);
        exp_q.push_back({r, 16'h0000, e});
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do @(posedge clk_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (!s_axi_rvalid_o);
    endtask

    task automatic fire(input logic [9:0] t, input logic [12:0] r, input logic [2:0] p);
        trap_cmd <= t;
        req_cmd <= r;
        @(posedge clk_i);
        trap_cmd <= 10'h000;
        req_cmd <= 13'h0000;
        repeat (2) @(posedge clk_i);
        // the pulse launched one edge earlier stands here
        chk("trap", {31'h0, p}, {31'h0, ova_trap_o, ovb_trap_o, cov_trap_o});
        @(posedge clk_i);
    endtask

    task automatic ext(input logic [2:0] v, input logic [15:0] e);
        ext_irq_i <= v;
        repeat (3) @(posedge clk_i);
        rd(RF, e, 2'b00);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
        if (s_axi_rvalid_o === 1'b1 && exp_q.size() > 0)
            chk("read", exp_q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
        if (s_axi_bvalid_o === 1'b1 && bexp_q.size() > 0)
            chk("bresp", {32'h0, bexp_q.pop_front()}, {32'h0, s_axi_bresp_o});
    end

    initial begin
        void'($urandom(32'hfcf080b1));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(TC, 16'h0000, 2'b00);
        rd(VC, 16'h0000, 2'b00);
        rd(RF, 16'h0000, 2'b00);
        wr(TC, 16'hffff);
        rd(TC, 16'hffde, 2'b00);
        chk("nesting", 34'h1, {33'h0, nesting_disable_o});
        wr(PL, 16'h0002);
        rd(PL, 16'h0000, 2'b00);
        chk("priority", 34'h0, {31'h0, cpu_priority_level_o});
        wr(TC, 16'h0000);
        wr(PL, 16'h0005);
        rd(PL, 16'h0005, 2'b00);
        chk("priority", 34'h5, {31'h0, cpu_priority_level_o});
        hold_off_active_i <= 1'b1;
        wr(VC, 16'hffff);
        rd(VC, 16'hc007, 2'b00);
        chk("table", 34'h1, {33'h0, alternate_table_select_o});
        hold_off_active_i <= 1'b0;
        wr(VC, 16'h0000);
        rd(VC, 16'h0000, 2'b00);
        for (int i = 0; i < 12; i++) begin
            wr(TC, CTL[i]);
            fire(CMD[i], 13'h0000, {EXP[i][14], EXP[i][13], EXP[i][12] | EXP[i][11]});
            rd(TC, EXP[i], 2'b00);
        end
        repeat (4) begin
            m = 13'($urandom());
            wr(RF, 16'h0000);
            fire(10'h000, m, 3'b000);
            rd(RF, {2'b00, m[12:4], 1'b0, m[3:0]}, 2'b00);
            chk("flags", {20'h0, m[12:4], 1'b0, m[3:0]}, {18'h0, request_flags_o});
        end
        wr(RF, 16'hffff);
        rd(RF, 16'h3fef, 2'b00);
        wr(RF, 16'h0000);
        ext(3'b111, 16'h0001);
        wr(RF, 16'h0000);
        wr(VC, 16'h0007);
        ext(3'b000, 16'h0001);
        wr(RF, 16'h0000);
        ext(3'b111, 16'h0000);
        wr(12'h020, 16'hffff);
        rd(12'h020, 16'h0000, 2'b10);
        wr(TC, 16'h8700);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(TC, 16'h0000, 2'b00);
        @(posedge clk_i);
        summarize();
    end
endmodule
